// ### hdl/bcd_addsub.v
// Purpose: 8-digit BCD or hex adder/subtractor, magnitude only
// Assumes: operands in range for the chosen radix
// Notes: subtraction is ten's or two's complement, borrow reported
`timescale 1ns/1ns
module bcd_addsub #(
  parameter DIGITS = 8
) (
  input wire [4*DIGITS-1:0] a, // minuend or augend
  input wire [4*DIGITS-1:0] b, // subtrahend or addend
  input wire sub, // high to subtract
  input wire hex, // high for hex radix
  output wire [4*DIGITS-1:0] y, // result digits
  output wire carry // carry out, or no-borrow on subtract
);
  wire [DIGITS:0] c;
  assign c[0] = sub;
  // one digit slice per nibble, with decimal correction
  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : dig
      wire [3:0] bd = sub ? (hex ? ~b[4*i+3:4*i] :
        (4'h9 - b[4*i+3:4*i])) : b[4*i+3:4*i];
      wire [4:0] s = {1'b0, a[4*i+3:4*i]} + {1'b0, bd} + {4'h0, c[i]};
      wire dc = hex ? s[4] : (s > 5'h09);
      wire [4:0] sc = (dc && !hex) ? (s + 5'h06) : s;
      assign y[4*i+3:4*i] = sc[3:0];
      assign c[i+1] = dc;
    end
  endgenerate
  assign carry = c[DIGITS];
endmodule

// ### hdl/macro_exec.v
// Purpose: macro command executor working on a BCD accumulator
// Assumes: command bytes arrive by valid/ready from fetch logic
// Notes: multiply, divide and A/D internals lie outside this block
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "macro_exec_consts.vh"
module macro_exec #(
  parameter NSTO = 12, // storage registers
  parameter SW = 4 // storage index width
) (
  input wire clk, // 100 MHz system clock
  input wire nrst, // async reset, active low
  input wire ce, // clock enable, freezes state when low
  input wire [7:0] cmd_byte, // next program byte
  input wire cmd_valid, // program byte present
  output wire cmd_ready, // byte taken this cycle
  input wire [3:0] port_in, // parallel port pin levels
  output reg [3:0] port_out, // parallel port drive value
  output reg [5:0] dig_out, // digital output terminals
  output reg [15:0] pc_q, // program address
  output reg branch_q, // pulse: pc reloaded by a branch
  output reg [15:0] rd_index, // EEPROM read index
  output reg [15:0] wr_index, // EEPROM write index
  output reg ee_wr_valid, // pulse: EEPROM write request
  output reg [15:0] ee_wr_addr, // EEPROM write start address
  output reg [31:0] ee_wr_data, // accumulator image to write
  output reg [11:0] long_timer, // long interval timer value
  output reg [11:0] short_timer, // short interval timer value
  output reg disp_valid, // pulse: one display byte
  output reg [2:0] disp_digit, // digit that the byte addresses
  output reg [7:0] disp_byte, // segment info for the digit
  output reg adc_req, // pulse: start A/D compare
  input wire adc_done, // A/D result ready
  input wire [31:0] adc_value, // A/D result, BCD
  output reg [31:0] acc_q, // accumulator
  output reg acc_neg_q, // accumulator sign
  output reg [31:0] sop_q, // second operand
  output reg [15:0] flags_q, // flag bits
  output reg st_pos, // positive status bit
  output reg negative_flag, // negative status bit
  output reg st_zero // zero status bit
);
  localparam S_OP = 3'h0;
  localparam S_ARG = 3'h1;
  localparam S_ARG2 = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_ADC = 3'h4;

  reg [2:0] state_q;
  reg [7:0] op_q;
  reg [7:0] arg_q;
  reg [3:0] cnt_q;
  reg [2:0] dig_q;
  reg [31:0] sto_q [0:NSTO-1];
  wire [3:0] port_sync;
  wire [31:0] as_y;
  wire as_c;
  wire as_sub;
  wire as_hex;
  wire [31:0] fix_y;
  wire [3:0] lo_nib;
  wire [3:0] hi_nib;
  wire [SW-1:0] sidx;
  wire sidx_ok;
  wire [15:0] imm16;
  integer k;

  pin_sync3 #(.W(4)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .din(port_in),
    .dout(port_sync)
  );

  // decimal or hex add/subtract on magnitudes
  assign as_sub = (op_q == `OP_DEC_SUB) || (op_q == `OP_HEX_SUB);
  assign as_hex = (op_q == `OP_HEX_ADD) || (op_q == `OP_HEX_SUB);
  bcd_addsub #(.DIGITS(8)) u_as (
    .a(acc_q),
    .b(sop_q),
    .sub(as_sub),
    .hex(as_hex),
    .y(as_y),
    .carry(as_c)
  );
  // negates a borrowed result, or adds the round-up carry, in the radix
  bcd_addsub #(.DIGITS(8)) u_fix (
    .a((state_q == S_ARG2) ? 32'h0 : (acc_q >> (4 * lo_nib))),
    .b((state_q == S_ARG2) ? as_y :
      {31'h0, (acc_q[4*lo_nib-1 -: 4] > 4'h4)}),
    .sub(state_q == S_ARG2),
    .hex(as_hex),
    .y(fix_y),
    .carry()
  );

  assign cmd_ready = ce && (state_q != S_ADC);
  assign lo_nib = cmd_byte[3:0];
  assign hi_nib = cmd_byte[7:4];
  assign sidx = cmd_byte[SW-1:0];
  assign sidx_ok = (cmd_byte < NSTO);
  assign imm16 = {arg_q, cmd_byte};

  // opcodes that carry one or more operand bytes
  function has_arg;
    input [7:0] op;
    begin
      case (op)
        `OP_NOP, `OP_SWAP, `OP_DEC_ADD, `OP_DEC_SUB, `OP_HEX_ADD,
        `OP_HEX_SUB, `OP_CMP, `OP_OR, `OP_AND, `OP_PORT_RD,
        `OP_ACC_PORT, `OP_ACC_OUTS, `OP_ADC_CMP: has_arg = 1'b0;
        default: has_arg = 1'b1;
      endcase
    end
  endfunction

  // branch condition from status bits
  function br_take;
    input [7:0] op;
    input z;
    input p;
    input n;
    begin
      case (op)
        `OP_BR_Z, `OP_BR_EQ: br_take = z;
        `OP_BR_NZ, `OP_BR_NE: br_take = !z;
        `OP_BR_P: br_take = p;
        `OP_BR_N: br_take = n;
        default: br_take = 1'b0;
      endcase
    end
  endfunction

  // command sequencer and datapath
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_OP;
      op_q <= 8'h00;
      arg_q <= 8'h00;
      cnt_q <= 4'h0;
      dig_q <= 3'h0;
      acc_q <= 32'h0;
      acc_neg_q <= `SIGN_POS;
      sop_q <= 32'h0;
      flags_q <= 16'h0;
      st_pos <= 1'b0;
      negative_flag <= 1'b0;
      st_zero <= 1'b0;
      port_out <= 4'h0;
      dig_out <= 6'h00;
      pc_q <= 16'h0;
      branch_q <= 1'b0;
      rd_index <= 16'h0;
      wr_index <= 16'h0;
      ee_wr_valid <= 1'b0;
      ee_wr_addr <= 16'h0;
      ee_wr_data <= 32'h0;
      long_timer <= 12'h0;
      short_timer <= 12'h0;
      disp_valid <= 1'b0;
      disp_digit <= 3'h0;
      disp_byte <= 8'h00;
      adc_req <= 1'b0;
      for (k = 0; k < NSTO; k = k + 1) begin
        sto_q[k] <= 32'h0;
      end
    end else if (ce) begin
      branch_q <= 1'b0;
      ee_wr_valid <= 1'b0;
      disp_valid <= 1'b0;
      adc_req <= 1'b0;
      if (cmd_valid && cmd_ready) begin
        pc_q <= pc_q + 16'h0001;
      end
      case (state_q)
        // opcode byte; operand-free commands finish here except add/sub and A/D compare
        S_OP: begin
          if (cmd_valid) begin
            op_q <= cmd_byte;
            if (has_arg(cmd_byte)) begin
              state_q <= S_ARG;
            end
            case (cmd_byte)
              `OP_SWAP: begin
                acc_q <= sop_q;
                sop_q <= acc_q;
              end
              `OP_DEC_ADD, `OP_DEC_SUB, `OP_HEX_ADD, `OP_HEX_SUB: begin
                state_q <= S_ARG2;
              end
              `OP_CMP: begin
                st_zero <= (acc_q == sop_q);
                st_pos <= (acc_q > sop_q);
                negative_flag <= (acc_q < sop_q);
              end
              `OP_OR, `OP_AND: begin
                acc_q <= (cmd_byte == `OP_OR) ? (acc_q | sop_q) :
                  (acc_q & sop_q);
              end
              `OP_PORT_RD: begin
                acc_q[3:0] <= port_sync;
                flags_q[15:12] <= port_sync;
                st_pos <= 1'b1;
                negative_flag <= 1'b0;
              end
              `OP_ACC_PORT: begin
                port_out <= acc_q[3:0];
              end
              `OP_ACC_OUTS: begin
                dig_out[3:0] <= acc_q[3:0];
              end
              `OP_ADC_CMP: begin
                adc_req <= 1'b1;
                state_q <= S_ADC;
              end
              default: begin
              end
            endcase
          end
        end
        // hex/decimal add-sub result latched one cycle after opcode
        S_ARG2: begin
          state_q <= S_OP;
          if (as_sub && !as_c) begin
            acc_q <= fix_y; // magnitude of the borrowed result
            acc_neg_q <= `SIGN_NEG;
            st_pos <= 1'b0;
            negative_flag <= 1'b1;
          end else begin
            acc_q <= as_y;
            acc_neg_q <= `SIGN_POS;
            st_pos <= 1'b1;
            negative_flag <= 1'b0;
          end
          st_zero <= (as_y == 32'h0);
        end
        // single operand byte
        S_ARG: begin
          if (cmd_valid) begin
            arg_q <= cmd_byte;
            state_q <= S_OP;
            st_pos <= 1'b1;
            negative_flag <= 1'b0;
            case (op_q)
              `OP_ACC_TO_STO, `OP_STO_TO_ACC, `OP_SOP_TO_STO,
              `OP_STO_TO_SOP: begin
                if (!sidx_ok) begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else if (op_q == `OP_ACC_TO_STO) begin
                  sto_q[sidx] <= acc_q;
                end else if (op_q == `OP_STO_TO_ACC) begin
                  acc_q <= sto_q[sidx];
                end else if (op_q == `OP_SOP_TO_STO) begin
                  sto_q[sidx] <= sop_q;
                end else begin
                  sop_q <= sto_q[sidx];
                end
              end
              `OP_ROUND: begin
                if (lo_nib == 4'h0 || cmd_byte >= {4'h0, `ROUND_LIMIT})
                  begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else begin
                  // clear n digits, carrying half up in BCD
                  acc_q <= fix_y << (4 * lo_nib);
                end
              end
              `OP_SHR, `OP_SHL: begin
                if (lo_nib == 4'h0 || cmd_byte >= {4'h0, `SHIFT_LIMIT})
                  begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else if (op_q == `OP_SHR) begin
                  acc_q <= acc_q >> (4 * lo_nib);
                end else begin
                  acc_q <= acc_q << (4 * lo_nib);
                end
              end
              `OP_FSET, `OP_FCLR, `OP_FTST: begin
                if (hi_nib != 4'h0) begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else if (op_q == `OP_FSET) begin
                  flags_q[lo_nib] <= 1'b1;
                end else if (op_q == `OP_FCLR) begin
                  flags_q[lo_nib] <= 1'b0;
                end else begin
                  st_zero <= !flags_q[lo_nib];
                end
              end
              `OP_K_PORT: begin
                port_out <= lo_nib;
              end
              `OP_K_OUTS: begin
                dig_out[3:0] <= lo_nib;
              end
              `OP_OUT_SET, `OP_OUT_CLR: begin
                if (cmd_byte == 8'h00 || cmd_byte > 8'h06) begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else begin
                  dig_out[cmd_byte[2:0] - 3'h1] <= (op_q == `OP_OUT_SET);
                end
              end
              `OP_LD_POS, `OP_LD_NEG: begin
                cnt_q <= (lo_nib == 4'h0) ? `LD_DEFAULT_N : lo_nib;
                if (lo_nib > `LD_DEFAULT_N) begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else begin
                  acc_q <= 32'h0;
                  acc_neg_q <= (op_q == `OP_LD_NEG) ? `SIGN_NEG :
                    `SIGN_POS;
                  state_q <= S_DATA;
                end
              end
              `OP_SHOW: begin
                // M in high nibble, N in low, M>=N
                if (hi_nib < lo_nib || hi_nib > 4'h7 || lo_nib == 4'h0) begin
                  st_pos <= 1'b0;
                  negative_flag <= 1'b1;
                end else begin
                  cnt_q <= hi_nib - lo_nib + 4'h1;
                  dig_q <= hi_nib[2:0];
                  state_q <= S_DATA;
                end
              end
              `OP_ACC_TO_EE, `OP_CMP_RIX, `OP_CMP_WIX, `OP_LD_TL,
              `OP_LD_TS, `OP_BR_Z, `OP_BR_EQ, `OP_BR_NZ, `OP_BR_NE,
              `OP_BR_P, `OP_BR_N: begin
                // two-byte operand: keep high byte, take low next
                st_pos <= st_pos;
                negative_flag <= negative_flag;
                cnt_q <= 4'h1;
                state_q <= S_DATA;
              end
              default: begin
              end
            endcase
          end
        end
        // trailing data bytes of multi-byte commands
        S_DATA: begin
          if (cmd_valid) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
              state_q <= S_OP;
            end
            case (op_q)
              `OP_LD_POS, `OP_LD_NEG: begin
                acc_q <= {acc_q[23:0], cmd_byte};
              end
              `OP_SHOW: begin
                disp_valid <= 1'b1;
                disp_digit <= dig_q;
                disp_byte <= cmd_byte;
                dig_q <= dig_q - 3'h1;
              end
              `OP_ACC_TO_EE: begin
                ee_wr_valid <= 1'b1;
                ee_wr_addr <= imm16;
                ee_wr_data <= acc_q;
              end
              `OP_CMP_RIX, `OP_CMP_WIX: begin
                st_zero <= ((op_q == `OP_CMP_RIX ? rd_index : wr_index)
                  == imm16);
                st_pos <= ((op_q == `OP_CMP_RIX ? rd_index : wr_index)
                  > imm16);
                negative_flag <= ((op_q == `OP_CMP_RIX ? rd_index :
                  wr_index) < imm16);
              end
              `OP_LD_TL: begin
                long_timer <= imm16[11:0];
              end
              `OP_LD_TS: begin
                short_timer <= imm16[11:0];
              end
              default: begin
                if (br_take(op_q, st_zero, st_pos, negative_flag)) begin
                  pc_q <= imm16;
                  branch_q <= 1'b1;
                end
              end
            endcase
          end
        end
        // waiting for A/D result
        S_ADC: begin
          if (adc_done) begin
            state_q <= S_OP;
            st_zero <= (adc_value == acc_q);
            st_pos <= (adc_value > acc_q);
            negative_flag <= (adc_value < acc_q);
          end
        end
        default: begin
          state_q <= S_OP;
        end
      endcase
    end
  end
endmodule

// ### hdl/macro_exec_consts.vh
// Purpose: constants for the macro command executor
// Assumes: byte-wide command stream, 32-bit BCD accumulator (8 nibbles)
// Notes: opcode values are a local encoding
`ifndef MACRO_EXEC_CONSTS_VH
`define MACRO_EXEC_CONSTS_VH
`define OP_NOP 8'h00
`define OP_ACC_TO_STO 8'h01
`define OP_STO_TO_ACC 8'h02
`define OP_SOP_TO_STO 8'h03
`define OP_STO_TO_SOP 8'h04
`define OP_SWAP 8'h05
`define OP_ACC_TO_EE 8'h06
`define OP_DEC_ADD 8'h10
`define OP_DEC_SUB 8'h11
`define OP_HEX_ADD 8'h12
`define OP_HEX_SUB 8'h13
`define OP_ROUND 8'h14
`define OP_SHR 8'h15
`define OP_SHL 8'h16
`define OP_CMP 8'h20
`define OP_CMP_RIX 8'h21
`define OP_CMP_WIX 8'h22
`define OP_FSET 8'h30
`define OP_FCLR 8'h31
`define OP_FTST 8'h32
`define OP_OR 8'h33
`define OP_AND 8'h34
`define OP_PORT_RD 8'h40
`define OP_ACC_PORT 8'h41
`define OP_K_PORT 8'h42
`define OP_K_OUTS 8'h43
`define OP_ACC_OUTS 8'h44
`define OP_OUT_SET 8'h45
`define OP_OUT_CLR 8'h46
`define OP_LD_POS 8'h50
`define OP_LD_NEG 8'h51
`define OP_BR_Z 8'h60
`define OP_BR_EQ 8'h61
`define OP_BR_NZ 8'h62
`define OP_BR_NE 8'h63
`define OP_BR_P 8'h64
`define OP_BR_N 8'h65
`define OP_SHOW 8'h70
`define OP_LD_TL 8'h80
`define OP_LD_TS 8'h81
`define OP_ADC_CMP 8'h90
`define ROUND_LIMIT 4'h5
`define SHIFT_LIMIT 4'h3
`define LD_DEFAULT_N 4'h4
`define FLAG_PORT_LO 4
`define FLAG_PORT_HI 7
`define NIB_W 4
`define ACC_W 32
`define SIGN_POS 1'b0
`define SIGN_NEG 1'b1
`endif

// ### hdl/pin_sync3.v
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: one clock, async active-low reset
// Notes: output follows once stages two and three agree
`timescale 1ns/1ns
module pin_sync3 #(
  parameter W = 4
) (
  input wire clk, // system clock
  input wire nrst, // async reset, active low
  input wire ce, // clock enable
  input wire [W-1:0] din, // raw pin levels
  output reg [W-1:0] dout // filtered levels
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  // shift chain; only stages two and three feed the filter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// ### verif/macro_exec_monitor.sv
// Purpose: port checks for the macro executor
// Assumes: one clock, async active-low reset
// Notes: sees only the top module's ports
`timescale 1ns/1ns
module macro_exec_monitor (
  input wire clk, // clock
  input wire nrst, // reset, active low
  input wire ce, // clock enable
  input wire cmd_valid, // byte offered
  input wire cmd_ready, // byte accepted
  input wire [3:0] port_out, // port drive
  input wire [5:0] dig_out, // output terminals
  input wire [15:0] pc_q, // program address
  input wire branch_q, // branch pulse
  input wire ee_wr_valid, // write pulse
  input wire [31:0] ee_wr_data, // write data
  input wire adc_req, // conversion start
  input wire adc_done, // conversion done
  input wire [31:0] acc_q, // accumulator
  input wire st_pos, // positive bit
  input wire negative_flag, // negative bit
  input wire st_zero // zero bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire take = cmd_valid && cmd_ready;
  // three quiet cycles with no byte and no conversion result
  sequence idle3;
    (!take && !adc_done) [*3];
  endsequence
  // a byte taken, not followed by a branch reload
  sequence stepped;
    take ##1 !branch_q;
  endsequence
  a_status_excl: assert property (!(st_pos && negative_flag))
    else $error("positive and negative bits both set");
  a_ee_data: assert property (ee_wr_valid |-> ee_wr_data == acc_q)
    else $error("eeprom data differs from accumulator");
  a_pc_step: assert property (
    stepped |-> pc_q == $past(pc_q) + 16'h0001)
    else $error("program address did not step by one");
  a_status_hold: assert property (
    idle3 |=> $stable({st_zero, st_pos, negative_flag}))
    else $error("status moved without a command");
  a_ready_ce: assert property (!ce |-> !cmd_ready)
    else $error("ready while clock enable low");
  a_adc_wait: assert property (adc_req && !adc_done |=> !cmd_ready)
    else $error("ready during conversion wait");
  a_adc_pulse: assert property (adc_req |=> !adc_req)
    else $error("conversion request longer than one cycle");
  a_dig_cause: assert property (
    $changed(dig_out) |-> $past(take) || $past(take, 2))
    else $error("outputs changed with no command");
  a_port_cause: assert property (
    $changed(port_out) |-> $past(take) || $past(take, 2))
    else $error("port changed with no command");
  a_branch_pulse: assert property (branch_q |=> !branch_q)
    else $error("branch pulse longer than one cycle");
endmodule
bind macro_exec macro_exec_monitor mon (.clk, .nrst, .ce, .cmd_valid,
  .cmd_ready, .port_out, .dig_out, .pc_q, .branch_q, .ee_wr_valid,
  .ee_wr_data, .adc_req, .adc_done, .acc_q, .st_pos, .negative_flag,
  .st_zero);

// ### verif/prog_feeder.sv
// Purpose: program memory that plays command bytes to the executor
// Assumes: a byte is taken when valid and ready meet at an edge
// Notes: gap after bytes 10..13 keeps the add/sub second cycle clear
`timescale 1ns/1ns
module prog_feeder (
  input wire clk, // clock
  input wire nrst, // reset, active low
  input wire cmd_ready, // executor takes byte
  input wire start, // pulse: play the memory
  input wire slow, // gap after every byte
  input wire [5:0] len, // program length
  output reg [7:0] cmd_byte, // byte offered
  output reg cmd_valid, // byte present
  output reg busy // still playing
);
  reg [7:0] mem [0:63]; // program bytes, filled by the bench
  reg [5:0] idx_q; // next byte to offer
  wire gap = slow || (cmd_byte >= 8'h10 && cmd_byte <= 8'h13);
  // offer bytes in order; an idle line shows the inverted last byte
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      busy <= 1'b0;
      idx_q <= 6'h00;
      cmd_byte <= 8'hFF;
    end else if (start) begin
      busy <= 1'b1;
      idx_q <= 6'h00;
    end else if (cmd_valid && cmd_ready && !gap && idx_q < len) begin
      cmd_byte <= mem[idx_q];
      idx_q <= idx_q + 6'h01;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      cmd_byte <= ~cmd_byte;
    end else if (!cmd_valid && busy && idx_q < len) begin
      cmd_valid <= 1'b1;
      cmd_byte <= mem[idx_q];
      idx_q <= idx_q + 6'h01;
    end else if (!cmd_valid) begin
      busy <= 1'b0;
    end
  end
endmodule

// ### verif/sensor_macro_command_executor_test.sv
// Purpose: self-checking bench for the macro executor
// Assumes: the feeder plays programs written into its memory
// Notes: table rows for arithmetic, hand tests after them
`timescale 1ns/1ns
module sensor_macro_command_executor_test;
  reg clk, nrst, ce, start, slow, adc_done;
  reg [3:0] port_in;
  reg [31:0] adc_value;
  reg [5:0] len;
  reg [1:0] adc_sh;
  wire [7:0] cmd_byte, disp_byte;
  wire [2:0] disp_digit;
  wire cmd_valid, cmd_ready, busy, branch_q, ee_wr_valid, disp_valid;
  wire adc_req, acc_neg_q, st_pos, negative_flag, st_zero;
  wire [3:0] port_out;
  wire [5:0] dig_out;
  wire [15:0] pc_q, ee_wr_addr, flags_q;
  wire [31:0] ee_wr_data, acc_q, sop_q;
  wire [11:0] long_timer, short_timer;
  integer n_mismatch, checked, n_br, n_ee, n_disp, i, k, w, b0;
  logic [7:0] p [$];
  localparam [17:0] BM = {6'b011100, 6'b101100, 6'b000011};
  typedef struct {
    logic [7:0] op, arg;
    logic [15:0] a, b, e;
    logic [2:0] zpn, msk;
  } row_t;
  row_t rows [0:12] = '{
    '{8'h10, 8'h00, 16'h0099, 16'h0001, 16'h0100, 3'b010, 3'b111},
    '{8'h11, 8'h00, 16'h0010, 16'h0025, 16'h0015, 3'b001, 3'b111},
    '{8'h12, 8'h00, 16'h000F, 16'h0001, 16'h0010, 3'b010, 3'b111},
    '{8'h13, 8'h00, 16'h0021, 16'h0020, 16'h0001, 3'b010, 3'b111},
    '{8'h33, 8'h00, 16'hF0F0, 16'h0F0F, 16'hFFFF, 3'b010, 3'b011},
    '{8'h34, 8'h00, 16'hF0F0, 16'h0FFF, 16'h00F0, 3'b010, 3'b011},
    '{8'h20, 8'h00, 16'h0025, 16'h0030, 16'h0025, 3'b001, 3'b111},
    '{8'h20, 8'h00, 16'h0030, 16'h0030, 16'h0030, 3'b100, 3'b111},
    '{8'h15, 8'h02, 16'h1234, 16'h0001, 16'h0012, 3'b010, 3'b011},
    '{8'h16, 8'h01, 16'h0234, 16'h0001, 16'h2340, 3'b010, 3'b011},
    '{8'h15, 8'h03, 16'h1234, 16'h0001, 16'h1234, 3'b001, 3'b011},
    '{8'h14, 8'h01, 16'h1295, 16'h0001, 16'h1300, 3'b010, 3'b011},
    '{8'h14, 8'h05, 16'h1235, 16'h0001, 16'h1235, 3'b001, 3'b011}};
  macro_exec dut (.clk(clk), .nrst(nrst), .ce(ce), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .port_in(port_in),
    .port_out(port_out), .dig_out(dig_out), .pc_q(pc_q),
    .branch_q(branch_q), .rd_index(), .wr_index(),
    .ee_wr_valid(ee_wr_valid), .ee_wr_addr(ee_wr_addr),
    .ee_wr_data(ee_wr_data), .long_timer(long_timer),
    .short_timer(short_timer), .disp_valid(disp_valid),
    .disp_digit(disp_digit), .disp_byte(disp_byte),
    .adc_req(adc_req), .adc_done(adc_done), .adc_value(adc_value),
    .acc_q(acc_q), .acc_neg_q(acc_neg_q), .sop_q(sop_q),
    .flags_q(flags_q), .st_pos(st_pos), .negative_flag(negative_flag),
    .st_zero(st_zero));
  prog_feeder fd (.clk(clk), .nrst(nrst), .cmd_ready(cmd_ready),
    .start(start), .slow(slow), .len(len), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .busy(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count pulses; answer a conversion three cycles after its request
  always @(posedge clk) begin
    n_br <= n_br + branch_q;
    n_ee <= n_ee + ee_wr_valid;
    n_disp <= n_disp + disp_valid;
    adc_sh <= {adc_sh[0], adc_req};
    adc_done <= adc_sh[1];
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ld(input [7:0] op, input [31:0] v);
    p = {p, op, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0]};
  endtask
  task ab(input [31:0] a, input [31:0] b);
    ld(8'h50, b);
    p = {p, 8'h05};
    ld(8'h50, a);
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // play the queued program and let its effects settle
  task go;
    integer j;
    for (j = 0; j < p.size(); j = j + 1) fd.mem[j] = p[j];
    @(posedge clk);
    len <= 6'(p.size());
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    w = 0;
    @(posedge clk);
    while (busy && w < 300) begin
      @(posedge clk);
      w = w + 1;
    end
    if (w >= 300) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
    repeat (4) @(posedge clk);
    #1;
    p.delete();
  endtask
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    len = 6'h00;
    port_in = 4'hA;
    adc_value = 32'h00001234;
    adc_sh = 2'h0;
    adc_done = 1'b0;
    {n_mismatch, checked, n_br, n_ee, n_disp} = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    #1;
    chk("reset", 32'h0, {acc_q[15:0], pc_q});
    $display("test reset done");
    for (i = 0; i <= 12; i = i + 1) begin
      slow <= i[0];
      ab({16'h0, rows[i].a}, {16'h0, rows[i].b});
      p = {p, rows[i].op};
      if (rows[i].arg != 8'h00) p = {p, rows[i].arg};
      go;
      chk("acc", {16'h0, rows[i].e}, acc_q);
      chk("sop", {16'h0, rows[i].b}, sop_q);
      chk("status", {29'h0, rows[i].zpn}, {29'h0, rows[i].msk &
        {st_zero, st_pos, negative_flag}});
      $display("test row %0d done", i);
    end
    for (i = 0; i < 3; i = i + 1) begin
      ab(i == 0 ? 32'h7 : 32'h5, 32'h7);
      p = {p, i == 2 ? 8'h10 : 8'h20};
      go;
      for (k = 0; k < 6; k = k + 1) begin
        b0 = n_br;
        p = '{8'h60 + k[7:0], 8'h00, 8'h30};
        go;
        chk("branch", {31'h0, BM[6*i+k]}, n_br - b0);
        if (BM[6*i+k]) chk("pc", 32'h30, {16'h0, pc_q});
      end
      $display("test branch set %0d done", i);
    end
    ab(32'h1111, 32'h2222);
    p = {p, 8'h01, 8'h03, 8'h03, 8'h04, 8'h02, 8'h04, 8'h04, 8'h03};
    go;
    chk("acc", 32'h2222, acc_q);
    chk("sop", 32'h1111, sop_q);
    p = '{8'h01, 8'h0C};
    go;
    chk("neg", 32'h1, {31'h0, negative_flag});
    p = '{8'h30, 8'h00, 8'h30, 8'h0F, 8'h31, 8'h00, 8'h32, 8'h01};
    go;
    chk("flags", 32'h8000, {16'h0, flags_q});
    chk("zero", 32'h1, {31'h0, st_zero});
    p = '{8'h32, 8'h0F, 8'h30, 8'h10};
    go;
    chk("flags", 32'h8000, {16'h0, flags_q});
    chk("neg", 32'h1, {31'h0, negative_flag});
    p = '{8'h21, 8'h00, 8'h00};
    go;
    chk("rd index", 32'h4, {29'h0, st_zero, st_pos, negative_flag});
    p = '{8'h22, 8'h00, 8'h05};
    go;
    chk("wr index", 32'h1, {29'h0, st_zero, st_pos, negative_flag});
    $display("test moves and flags done");
    p = '{8'h40};
    go;
    chk("port read", 32'hAA, {24'h0, acc_q[3:0], flags_q[15:12]});
    p = '{8'h42, 8'h05};
    go;
    chk("port", 32'h5, {28'h0, port_out});
    p = '{8'h41, 8'h43, 8'h03, 8'h45, 8'h06, 8'h46, 8'h01};
    go;
    chk("port", 32'hA, {28'h0, port_out});
    chk("outs", 32'h22, {26'h0, dig_out});
    p = '{8'h44, 8'h06, 8'h12, 8'h34, 8'h80, 8'h01, 8'h23, 8'h81, 8'h04,
      8'h56, 8'h70, 8'h21, 8'h0F, 8'h0E};
    go;
    chk("outs", 32'hA, {28'h0, dig_out[3:0]});
    chk("ee", 32'h11234, {n_ee[15:0], ee_wr_addr});
    chk("timer", 32'h123456, {8'h0, long_timer, short_timer});
    chk("display", 32'h2, n_disp);
    chk("digit", 32'h10E, {21'h0, disp_digit, disp_byte});
    p = '{8'h51, 8'h02, 8'h12, 8'h34};
    go;
    chk("load neg", 32'h11234, {15'h0, acc_neg_q, acc_q[15:0]});
    p = '{8'h50, 8'h02, 8'h12, 8'h34, 8'h90};
    go;
    chk("adc zero", 32'h1, {31'h0, st_zero});
    $display("test io and misc done");
    test_done;
  end
endmodule
